// File: ppa_axis.v
// positioning pulse-output axis with homing, apb register file and clear pulse
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "ppa_defines.vh"

module ppa_axis #(
  parameter MS_CYCLES    = `PPA_MS_NS / `PPA_CLK_PERIOD_NS,
  parameter SCAN_CYCLES  = `PPA_SCAN_US * 1000 / `PPA_CLK_PERIOD_NS,
  parameter CLEAR_CYCLES = `PPA_CLEAR_MS * MS_CYCLES + SCAN_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        near_point_in,
  input  wire        zero_point_in,
  input  wire        abs_load_valid,
  input  wire [31:0] abs_load_data,
  output reg         axis2_pulse_output,
  output reg         direction_out,
  output reg  [15:0] drive_counter_clear_output,
  output reg         completion_irq
);

  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_MOVE  = 3'd1;
  localparam [2:0] S_FAST  = 3'd2;
  localparam [2:0] S_CRAWL = 3'd3;
  localparam [2:0] S_CLEAR = 3'd4;

  localparam [31:0] MS_LAST    = MS_CYCLES - 1;
  localparam [31:0] CLEAR_LAST = CLEAR_CYCLES - 1;

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg [31:0] acc_total;
  reg [31:0] abs_pos;
  reg [31:0] max_speed;
  reg [15:0] base_speed;
  reg [15:0] accel_time;
  reg [15:0] clear_sel;
  reg [15:0] crawl_speed;
  reg [31:0] home_speed;
  reg [15:0] env_stage;
  reg [8:0]  ctrl;
  reg        done_flag;
  reg        refused_flag;
  reg [31:0] move_target;
  reg [31:0] move_speed;

  reg [2:0]  state;
  reg        dog_mode;
  reg [7:0]  env_total;
  reg [31:0] remaining;
  reg [31:0] ramp_pulses;
  reg [17:0] cur_speed;
  reg [23:0] phase;
  reg [31:0] err;
  reg [31:0] ms_cnt;
  reg [31:0] clr_cnt;
  reg        done_evt;
  reg [31:0] rd_word;
  reg        rd_ok;

  wire near_sync;
  wire zero_sync;

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  ppa_sync u_near_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (near_point_in),
    .sync_out (near_sync)
  );

  ppa_sync u_zero_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (zero_point_in),
    .sync_out (zero_sync)
  );

  wire near_active = near_sync ^ ctrl[`PPA_CTRL_NEAR_INV];
  wire zero_active = zero_sync ^ ctrl[`PPA_CTRL_ZERO_INV];

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  wire setup  = psel & ~penable;
  wire access = psel & penable & pready;
  wire [7:0] cmd_bits = pwdata[7:0];

  always @* begin
    rd_ok   = 1'b1;
    rd_word = 32'h00000000;
    case (paddr)
      `PPA_ADDR_ACC_HI:    rd_word = {16'h0000, acc_total[31:16]};
      `PPA_ADDR_ACC_LO:    rd_word = {16'h0000, acc_total[15:0]};
      `PPA_ADDR_ABS_HI:    rd_word = {16'h0000, abs_pos[31:16]};
      `PPA_ADDR_ABS_LO:    rd_word = {16'h0000, abs_pos[15:0]};
      `PPA_ADDR_MAX_HI:    rd_word = {16'h0000, max_speed[31:16]};
      `PPA_ADDR_MAX_LO:    rd_word = {16'h0000, max_speed[15:0]};
      `PPA_ADDR_BASE:      rd_word = {16'h0000, base_speed};
      `PPA_ADDR_ACCEL:     rd_word = {16'h0000, accel_time};
      `PPA_ADDR_CLR_SEL:   rd_word = {16'h0000, clear_sel};
      `PPA_ADDR_CRAWL:     rd_word = {16'h0000, crawl_speed};
      `PPA_ADDR_HOME_HI:   rd_word = {16'h0000, home_speed[31:16]};
      `PPA_ADDR_HOME_LO:   rd_word = {16'h0000, home_speed[15:0]};
      `PPA_ADDR_ENV_STAGE: rd_word = {16'h0000, env_stage};
      `PPA_ADDR_CTRL:      rd_word = {23'h000000, ctrl};
      `PPA_ADDR_STATUS:    rd_word = {28'h0000000, refused_flag, done_flag,
                                      dog_mode & (state != S_IDLE),
                                      state != S_IDLE};
      `PPA_ADDR_TARGET:    rd_word = move_target;
      `PPA_ADDR_SPEED:     rd_word = move_speed;
      `PPA_ADDR_CMD:       rd_word = 32'h00000000;
      default:             rd_ok   = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~rd_ok;
      if (setup && !pwrite) begin
        prdata <= rd_ok ? rd_word : 32'h00000000;
      end
    end
  end

  wire wr = access & pwrite;

  // --------------------------------------------------------------------------
  // parameter checks and command start
  // --------------------------------------------------------------------------
  wire [31:0] base10 = {12'h000, base_speed, 4'h0} - {15'h0000, base_speed, 1'b0} - {15'h0000, base_speed, 1'b0}
                       - {15'h0000, base_speed, 1'b0};
  wire params_ok = (max_speed >= `PPA_MAX_SPEED_MIN) && (max_speed <= `PPA_MAX_SPEED_MAX)
                 && (accel_time >= `PPA_ACCEL_MIN) && (accel_time <= `PPA_ACCEL_MAX)
                 && (base10 < max_speed);

  wire move_speed_ok = (move_speed >= {16'h0000, base_speed}) && (move_speed <= max_speed);
  wire home_speed_ok = (home_speed >= {16'h0000, base_speed}) && (home_speed <= max_speed)
                     && (crawl_speed >= base_speed) && ({16'h0000, crawl_speed} <= max_speed);

  wire cmd_wr    = wr && (paddr == `PPA_ADDR_CMD) && (state == S_IDLE);
  wire req_move  = cmd_wr & cmd_bits[`PPA_CMD_MOVE];
  wire req_home  = cmd_wr & ~cmd_bits[`PPA_CMD_MOVE] &
                   (cmd_bits[`PPA_CMD_DOG_HOME] | cmd_bits[`PPA_CMD_PLAIN_HOME]);
  wire start_move = req_move & params_ok & move_speed_ok & (move_target != 32'h00000000);
  wire start_home = req_home & params_ok & home_speed_ok;
  wire refuse_evt = (req_move & ~start_move) | (req_home & ~start_home);

  // --------------------------------------------------------------------------
  // speed ramp and pulse generator
  // --------------------------------------------------------------------------
  wire moving  = (state == S_MOVE) | (state == S_FAST) | (state == S_CRAWL);
  wire running = moving & ~ctrl[`PPA_CTRL_STOP];
  wire decel   = (state == S_MOVE) && (remaining <= ramp_pulses);
  wire [17:0] tgt_speed = (state == S_MOVE)  ? (decel ? {2'b00, base_speed} : move_speed[17:0]) :
                          (state == S_FAST)  ? home_speed[17:0] :
                          {2'b00, crawl_speed};
  wire [17:0] tgt_ext   = (state == S_MOVE && decel) ? {2'b00, base_speed} : tgt_speed;
  wire        ms_tick   = (ms_cnt == MS_LAST);
  wire [31:0] ramp_delta = max_speed - {16'h0000, base_speed};
  wire [31:0] err_add   = err + (ms_tick ? ramp_delta : 32'h00000000);
  wire        ramp_step = running && (err_add >= {16'h0000, accel_time}) && (cur_speed != tgt_ext);

  wire [24:0] ph_sum  = {1'b0, phase} + {6'h00, cur_speed, 1'b0};
  wire        ph_wrap = running && (ph_sum >= {1'b0, `PPA_CLK_HZ});
  wire        pulse_evt = ph_wrap & ~axis2_pulse_output;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt <= 32'h00000000;
    end else if (ms_tick) begin
      ms_cnt <= 32'h00000000;
    end else begin
      ms_cnt <= ms_cnt + 32'h00000001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err                <= 32'h00000000;
      cur_speed          <= 18'h00000;
      phase              <= 24'h000000;
      axis2_pulse_output <= 1'b0;
    end else if (!moving) begin
      err                <= 32'h00000000;
      cur_speed          <= {2'b00, base_speed};
      phase              <= 24'h000000;
      axis2_pulse_output <= 1'b0;
    end else if (running) begin
      if (cur_speed == tgt_ext) begin
        err <= 32'h00000000;
      end else if (ramp_step) begin
        err <= err_add - {16'h0000, accel_time};
      end else begin
        err <= err_add;
      end
      if (ramp_step) begin
        cur_speed <= (cur_speed < tgt_ext) ? cur_speed + 18'h00001 : cur_speed - 18'h00001;
      end
      if (ph_wrap) begin
        phase              <= ph_sum[23:0] - `PPA_CLK_HZ;
        axis2_pulse_output <= ~axis2_pulse_output;
      end else begin
        phase <= ph_sum[23:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  wire lim_hit = direction_out ? ctrl[`PPA_CTRL_FWD_LIM] : ctrl[`PPA_CTRL_REV_LIM];
  wire both_lim = ctrl[`PPA_CTRL_FWD_LIM] & ctrl[`PPA_CTRL_REV_LIM];
  wire origin = (state == S_CRAWL) && (dog_mode ? zero_active : ~near_active);
  wire lim_abort = dog_mode && ((state == S_FAST) || (state == S_CRAWL)) && both_lim;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= S_IDLE;
      dog_mode      <= 1'b0;
      direction_out <= 1'b0;
      env_total     <= 8'h00;
      env_stage     <= `PPA_RST_WORD;
      remaining     <= `PPA_RST_LONG;
      ramp_pulses   <= `PPA_RST_LONG;
      clr_cnt       <= 32'h00000000;
      done_evt      <= 1'b0;
    end else begin
      done_evt <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start_move) begin
            state         <= S_MOVE;
            dog_mode      <= 1'b0;
            direction_out <= cmd_bits[`PPA_CMD_MOVE_DIR];
            remaining     <= move_target;
            ramp_pulses   <= 32'h00000000;
            env_total     <= pwdata[`PPA_CMD_STAGES_MSB:`PPA_CMD_STAGES_LSB];
            env_stage     <= 16'h0001;
          end else if (start_home) begin
            state         <= S_FAST;
            dog_mode      <= cmd_bits[`PPA_CMD_DOG_HOME];
            direction_out <= ctrl[`PPA_CTRL_HOME_DIR];
          end
        end
        S_MOVE: begin
          if (pulse_evt) begin
            if (remaining == 32'h00000001) begin
              if ({8'h00, env_total} >= env_stage) begin
                env_stage   <= env_stage + 16'h0001;
                remaining   <= move_target;
                ramp_pulses <= 32'h00000000;
              end else begin
                state     <= S_IDLE;
                env_stage <= 16'h0000;
                done_evt  <= 1'b1;
              end
            end else begin
              remaining <= remaining - 32'h00000001;
              if (!decel && cur_speed < tgt_ext) begin
                ramp_pulses <= ramp_pulses + 32'h00000001;
              end
            end
          end
        end
        S_FAST, S_CRAWL: begin
          if (lim_abort) begin
            state <= S_IDLE;
          end else if (origin) begin
            clr_cnt  <= 32'h00000000;
            if (ctrl[`PPA_CTRL_CLR_VALID]) begin
              state <= S_CLEAR;
            end else begin
              state    <= S_IDLE;
              done_evt <= 1'b1;
            end
          end else begin
            if (state == S_FAST && near_active) begin
              state <= S_CRAWL;
            end
            if (dog_mode && lim_hit) begin
              direction_out <= ~direction_out;
            end
          end
        end
        S_CLEAR: begin
          if (clr_cnt == CLEAR_LAST) begin
            state    <= S_IDLE;
            done_evt <= 1'b1;
          end else begin
            clr_cnt <= clr_cnt + 32'h00000001;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // clear output and completion
  // --------------------------------------------------------------------------
  wire [3:0] clr_idx = ctrl[`PPA_CTRL_CLR_DESIG] ? clear_sel[3:0] : `PPA_DEFAULT_CLR;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_counter_clear_output <= 16'h0000;
      completion_irq             <= 1'b0;
    end else begin
      drive_counter_clear_output <= (state == S_CLEAR && ctrl[`PPA_CTRL_CLR_VALID]) ?
                                    (16'h0001 << clr_idx) : 16'h0000;
      completion_irq <= done_evt & ctrl[`PPA_CTRL_IRQ_EN];
    end
  end

  // --------------------------------------------------------------------------
  // register writes, position tracking and sticky status
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_total    <= `PPA_RST_LONG;
      abs_pos      <= `PPA_RST_LONG;
      max_speed    <= `PPA_RST_LONG;
      base_speed   <= `PPA_RST_WORD;
      accel_time   <= `PPA_RST_WORD;
      clear_sel    <= `PPA_RST_WORD;
      crawl_speed  <= `PPA_RST_WORD;
      home_speed   <= `PPA_RST_LONG;
      ctrl         <= 9'h000;
      move_target  <= `PPA_RST_LONG;
      move_speed   <= `PPA_RST_LONG;
      done_flag    <= 1'b0;
      refused_flag <= 1'b0;
    end else begin
      if (pulse_evt) begin
        acc_total <= acc_total + 32'h00000001;
        abs_pos   <= direction_out ? abs_pos + 32'h00000001 : abs_pos - 32'h00000001;
      end
      if (abs_load_valid) begin
        abs_pos <= abs_load_data;
      end
      if (wr) begin
        case (paddr)
          `PPA_ADDR_ACC_HI:  acc_total[31:16]  <= pwdata[15:0];
          `PPA_ADDR_ACC_LO:  acc_total[15:0]   <= pwdata[15:0];
          `PPA_ADDR_ABS_HI:  abs_pos[31:16]    <= pwdata[15:0];
          `PPA_ADDR_ABS_LO:  abs_pos[15:0]     <= pwdata[15:0];
          `PPA_ADDR_MAX_HI:  max_speed[31:16]  <= pwdata[15:0];
          `PPA_ADDR_MAX_LO:  max_speed[15:0]   <= pwdata[15:0];
          `PPA_ADDR_BASE:    base_speed        <= pwdata[15:0];
          `PPA_ADDR_ACCEL:   accel_time        <= pwdata[15:0];
          `PPA_ADDR_CLR_SEL: clear_sel         <= pwdata[15:0];
          `PPA_ADDR_CRAWL:   crawl_speed       <= pwdata[15:0];
          `PPA_ADDR_HOME_HI: home_speed[31:16] <= pwdata[15:0];
          `PPA_ADDR_HOME_LO: home_speed[15:0]  <= pwdata[15:0];
          `PPA_ADDR_CTRL:    ctrl              <= pwdata[8:0];
          `PPA_ADDR_TARGET:  move_target       <= pwdata;
          `PPA_ADDR_SPEED:   move_speed        <= pwdata;
          default: begin
          end
        endcase
      end
      // write-one-to-clear, a new event in the same cycle wins
      if (done_evt) begin
        done_flag <= 1'b1;
      end else if (wr && paddr == `PPA_ADDR_STATUS && pwdata[`PPA_STAT_DONE]) begin
        done_flag <= 1'b0;
      end
      if (refuse_evt || lim_abort) begin
        refused_flag <= 1'b1;
      end else if (wr && paddr == `PPA_ADDR_STATUS && pwdata[`PPA_STAT_REFUSED]) begin
        refused_flag <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// File: ppa_defines.vh
// register map, field positions, reset values and timing figures of the pulse axis
`ifndef PPA_DEFINES_VH
`define PPA_DEFINES_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define PPA_ADDR_ACC_HI    8'h00
`define PPA_ADDR_ACC_LO    8'h04
`define PPA_ADDR_ABS_HI    8'h08
`define PPA_ADDR_ABS_LO    8'h0c
`define PPA_ADDR_MAX_HI    8'h10
`define PPA_ADDR_MAX_LO    8'h14
`define PPA_ADDR_BASE      8'h18
`define PPA_ADDR_ACCEL     8'h1c
`define PPA_ADDR_CLR_SEL   8'h20
`define PPA_ADDR_CRAWL     8'h24
`define PPA_ADDR_HOME_HI   8'h28
`define PPA_ADDR_HOME_LO   8'h2c
`define PPA_ADDR_ENV_STAGE 8'h30
`define PPA_ADDR_CTRL      8'h34
`define PPA_ADDR_STATUS    8'h38
`define PPA_ADDR_TARGET    8'h3c
`define PPA_ADDR_SPEED     8'h40
`define PPA_ADDR_CMD       8'h44

// ----------------------------------------------------------------------------
// control word bits
// ----------------------------------------------------------------------------
`define PPA_CTRL_STOP      0
`define PPA_CTRL_IRQ_EN    1
`define PPA_CTRL_CLR_VALID 2
`define PPA_CTRL_CLR_DESIG 3
`define PPA_CTRL_HOME_DIR  4
`define PPA_CTRL_FWD_LIM   5
`define PPA_CTRL_REV_LIM   6
`define PPA_CTRL_NEAR_INV  7
`define PPA_CTRL_ZERO_INV  8

// ----------------------------------------------------------------------------
// status word bits
// ----------------------------------------------------------------------------
`define PPA_STAT_PULSE_BUSY 0
`define PPA_STAT_HOME_BUSY  1
`define PPA_STAT_DONE       2
`define PPA_STAT_REFUSED    3

// ----------------------------------------------------------------------------
// command word bits
// ----------------------------------------------------------------------------
`define PPA_CMD_MOVE       0
`define PPA_CMD_DOG_HOME   1
`define PPA_CMD_PLAIN_HOME 2
`define PPA_CMD_MOVE_DIR   3
`define PPA_CMD_STAGES_LSB 8
`define PPA_CMD_STAGES_MSB 15

// ----------------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------------
`define PPA_RST_WORD       16'h0000
`define PPA_RST_LONG       32'h00000000
`define PPA_MAX_SPEED_MIN  32'd10
`define PPA_MAX_SPEED_MAX  32'd200000
`define PPA_ACCEL_MIN      16'd50
`define PPA_ACCEL_MAX      16'd5000
`define PPA_DEFAULT_CLR    4'he

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define PPA_CLK_HZ         24'd10000000
`define PPA_CLK_PERIOD_NS  100
`define PPA_MS_NS          1000000
`define PPA_CLEAR_MS       20
`define PPA_SCAN_US        1000

`endif

// File: ppa_sync.v
// two-flop synchroniser for one asynchronous input level
`timescale 1ns/1ns
`default_nettype none

module ppa_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire async_in,
  output reg  sync_out
);

  reg meta;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// File: ppa_axis_asserts.sv
// port assertions of the pulse axis
`timescale 1ns/1ns
`default_nettype none
module ppa_axis_asserts #(
  parameter CLEAR_CYCLES = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] drive_counter_clear_output,
  input wire logic        completion_irq
);
  // ----
  // checks
  // ----
  logic [15:0] clr_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) clr_cnt <= 16'h0000;
    else clr_cnt <= (|drive_counter_clear_output) ? clr_cnt + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_setup_ready; psel && !penable |=> pready; endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready longer than one cycle");
  property p_err_access; pslverr |-> pready && psel && penable; endproperty
  a_err_access: assert property (p_err_access) else $error("error outside access");
  property p_err_rd; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_rd: assert property (p_err_rd) else $error("refused read data not zero");
  property p_clr_hot; $onehot0(drive_counter_clear_output); endproperty
  a_clr_hot: assert property (p_clr_hot) else $error("clear not one-hot");
  property p_clr_len; clr_cnt <= CLEAR_CYCLES; endproperty
  a_clr_len: assert property (p_clr_len) else $error("clear pulse too long");
  property p_clr_steady; (|drive_counter_clear_output) && (|$past(drive_counter_clear_output))
    |-> $stable(drive_counter_clear_output); endproperty
  a_clr_steady: assert property (p_clr_steady) else $error("clear moved mid pulse");
  property p_irq_one; completion_irq |=> !completion_irq; endproperty
  a_irq_one: assert property (p_irq_one) else $error("irq longer than one cycle");
endmodule
`default_nettype wire

// File: ppa_drive_model.sv
// servo drive model: follows pulses, counts clear pulses, drives home sensors
`timescale 1ns/1ns
`default_nettype none
module ppa_drive_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pulse,
  input  wire logic        dir,
  input  wire logic [15:0] clr,
  input  wire logic        inv_n,
  input  wire logic        inv_z,
  output wire logic        near,
  output wire logic        zero,
  output var  int          pos,
  output var  int          n_clr
);
  // ----
  // position and sensors
  // ----
  logic prev_p;
  logic prev_c;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 0;
      n_clr <= 0;
      prev_p <= 1'b0;
      prev_c <= 1'b0;
    end else begin
      prev_p <= pulse;
      prev_c <= |clr;
      if (pulse && !prev_p) pos <= dir ? pos + 1 : pos - 1;
      if ((|clr) && !prev_c) n_clr <= n_clr + 1;
    end
  end
  // dog spans 8 and up, zero mark at 10; polarity set by the bench
  assign near = (pos >= 8) ^ inv_n;
  assign zero = (pos >= 10) ^ inv_z;
endmodule
`default_nettype wire

// File: tb_top.sv
// testbench of the pulse axis
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ----
  // bench
  // ----
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ld = 0, inv_n = 0, inv_z = 0;
  logic        pready, pslverr, pulse, dir, irq, near, zero;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, ld_data = 32'h0, prdata, v;
  logic [15:0] clr;
  int          pos, n_clr, n_fail = 0, n_checks = 0, seed = 32'h5ab5, i;
  logic [32:0] q_rd[$];
  logic [15:0] q_clr[$];
  logic [31:0] mx[8] = '{200001, 200000, 200000, 200000, 200000, 200000, 9, 200000};
  logic [31:0] bs[8] = '{19999, 20000, 19999, 19999, 19999, 19999, 0, 19999};
  logic [31:0] ac[8] = '{50, 50, 49, 5001, 50, 50, 50, 50};
  logic [31:0] sp[8] = '{200000, 200000, 200000, 200000, 19998, 200001, 9, 200000};
  always #50 pclk = ~pclk;
  ppa_axis #(.MS_CYCLES(10), .SCAN_CYCLES(5), .CLEAR_CYCLES(205)) ppa_axis_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .near_point_in(near), .zero_point_in(zero), .abs_load_valid(ld),
    .abs_load_data(ld_data), .axis2_pulse_output(pulse), .direction_out(dir), .drive_counter_clear_output(clr),
    .completion_irq(irq));
  ppa_drive_model ppa_drive_model_inst (.pclk(pclk), .presetn(presetn), .pulse(pulse), .dir(dir), .clr(clr),
    .inv_n(inv_n), .inv_z(inv_z), .near(near), .zero(zero), .pos(pos), .n_clr(n_clr));
  task chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) begin
      n_fail++;
      stop_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e);
    q_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task wait_irq;
    for (i = 0; i < 40000 && irq !== 1'b1; i++) @(posedge pclk);
    if (i == 40000) begin
      n_fail++;
      stop_test;
    end
  endtask
  // scoreboard: oldest note against each read and each clear pulse
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) chk("read data", q_rd.pop_front(), {pslverr, prdata});
    if ($rose(|clr)) chk("clear output", 33'(q_clr.pop_front()), 33'(clr));
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (v = 0; v <= 32'h48; v += 4) rd(v[7:0], {v == 32'h48, 32'h0});
    for (v = 32'h10; v <= 32'h2c; v += 4) begin
      i = $random(seed);
      wr(v[7:0], i);
      rd(v[7:0], {17'h0, i[15:0]});
    end
    wr(8'h30, 32'hffff);
    rd(8'h30, 33'h0);
    wr(8'h34, 32'h3);
    wr(8'h3c, 32'h4);
    for (int r = 0; r < 8; r++) begin
      wr(8'h10, {16'h0, mx[r][31:16]});
      wr(8'h14, {16'h0, mx[r][15:0]});
      wr(8'h18, bs[r]);
      wr(8'h1c, ac[r]);
      wr(8'h40, sp[r]);
      wr(8'h44, 32'h109);
      repeat (3) @(posedge pclk);
      rd(8'h38, r < 7 ? 33'h8 : 33'h1);
      if (r < 7) wr(8'h38, 32'hc);
    end
    repeat (1500) @(posedge pclk);
    chk("drive position", 33'h0, 33'(pos));
    rd(8'h30, 33'h1);
    wr(8'h34, 32'h2);
    wait_irq;
    chk("drive position", 33'h8, 33'(pos));
    rd(8'h38, 33'h4);
    rd(8'h04, 33'h8);
    rd(8'h0c, 33'h8);
    wr(8'h38, 32'hc);
    wr(8'h28, 32'h3);
    wr(8'h2c, 32'hd40);
    wr(8'h24, 32'd40000);
    wr(8'h20, 32'h5);
    inv_n <= 1'b1;
    inv_z <= 1'b1;
    wr(8'h34, 32'h19e);
    q_clr.push_back(16'h0020);
    wr(8'h44, 32'h2);
    rd(8'h38, 33'h3);
    wait_irq;
    chk("home travel", 33'h1, 33'(pos >= 10));
    rd(8'h38, 33'h4);
    wr(8'h38, 32'hc);
    wr(8'h34, 32'h186);
    q_clr.push_back(16'h4000);
    v = pos;
    wr(8'h44, 32'h4);
    rd(8'h38, 33'h1);
    wait_irq;
    chk("home travel", 33'h1, 33'($signed(pos) < $signed(v)));
    wr(8'h34, 32'h192);
    wr(8'h44, 32'h2);
    wait_irq;
    chk("clear pulses", 33'h2, 33'(n_clr));
    v = $random(seed);
    ld_data <= v;
    ld <= 1'b1;
    @(posedge pclk);
    ld <= 1'b0;
    rd(8'h08, {17'h0, v[31:16]});
    rd(8'h0c, {17'h0, v[15:0]});
    stop_test;
  end
endmodule
bind ppa_axis ppa_axis_asserts #(.CLEAR_CYCLES(CLEAR_CYCLES)) ppa_axis_asserts_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .drive_counter_clear_output(drive_counter_clear_output), .completion_irq(completion_irq));
`default_nettype wire
